// ---- rtl/hfu_consts.svh ----
// Constants shared by both ends of the framed serial link.
// Assumes inclusion by bare name; holds definitions only.
`ifndef HFU_CONSTS_SVH
`define HFU_CONSTS_SVH
// ==========================================================
// Framing
`define HFU_FLAG        8'h7e
`define HFU_CRC_INIT    16'hffff
`define HFU_CRC_POLY    16'h8408
`define HFU_CRC_GOOD    16'hf0b8
`define HFU_STUFF_ONES  3'd5
`define HFU_FLAG_ONES   3'd6
`define HFU_ABORT_ONES  3'd7
`define HFU_BYTE_BITS   5'd8
`define HFU_FCS_BITS    5'd16
// ==========================================================
// Characters sent to the host
`define HFU_CHAR_GOOD   8'h47
`define HFU_CHAR_ERR    8'h65
`define HFU_CHAR_ABORT  8'h41
`define HFU_CHAR_CONN_C 8'h63
`define HFU_CHAR_CONN_D 8'h64
`define HFU_CHAR_CONN_V 8'h76
// ==========================================================
// Host register map (byte addresses) and status bits
`define HFU_ADDR_TX     4'h0
`define HFU_ADDR_RX     4'h4
`define HFU_ADDR_STAT   4'h8
`define HFU_STAT_PEND   0
`define HFU_STAT_READY  1
`define HFU_STAT_AVAIL  2
`define HFU_STAT_OVER   3
`endif

// ---- rtl/hfu_pkg.sv ----
// Types and check-sequence helpers for the framed serial link.
// Assumes hfu_consts.svh on the include path.
`include "hfu_consts.svh"
package hfu_pkg;
    // ======================================================
    // Transmit sequencer states
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_FLAG = 4'b0010,
        TX_DATA = 4'b0100,
        TX_FCS  = 4'b1000
    } hfu_tx_state_t;
    // Receive hunter states
    typedef enum logic [2:0] {
        RX_HUNT  = 3'b001,
        RX_OPEN  = 3'b010,
        RX_FRAME = 3'b100
    } hfu_rx_state_t;
    typedef logic [8:0] hfu_char_t;    // Ninth bit plus data byte

    // One bit of the reflected 16-bit check sequence
    function automatic logic [15:0] hfu_crc_bit(input logic [15:0] crc,
                                                input logic        b);
        hfu_crc_bit = (crc[0] ^ b) ? ((crc >> 1) ^ `HFU_CRC_POLY)
                                   : (crc >> 1);
    endfunction

    // Whole byte, low bit first as it travels on the line
    function automatic logic [15:0] hfu_crc_byte(input logic [15:0] crc,
                                                 input logic [7:0]  d);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = hfu_crc_bit(c, d[i]);
        end
        hfu_crc_byte = c;
    endfunction
endpackage

// ---- rtl/hfu_link_if.sv ----
// Character link between the host controller and the framing device.
// Assumes both ends share clk; all signals are synchronous to it.
`timescale 1ns/1ps
interface hfu_link_if;
    logic             h2d_valid;        // Host character strobe
    hfu_pkg::hfu_char_t h2d_char;       // Host character, bit 8 escape
    logic             cts_n;            // Low: device takes a character
    logic             d2h_valid;        // Device character strobe
    hfu_pkg::hfu_char_t d2h_char;       // Device character, bit 8 marker
    logic             frame_end_marker; // High while result is shown

    modport dev  (input  h2d_valid, h2d_char,
                  output cts_n, d2h_valid, d2h_char, frame_end_marker);
    modport host (output h2d_valid, h2d_char,
                  input  cts_n, d2h_valid, d2h_char, frame_end_marker);
endinterface

// ---- rtl/hfu_device.sv ----
// Framing device end: builds, checks and delimits frames on the line.
// Assumes a data pump that strobes one bit each way per line bit time.
// Function
// - Host does correction and compression, not device
// - Framing only when frame mode enabled
// - Ninth bit escapes when enabled, else ignored
// - Idle connected line sends back-to-back flags
// - Check sequence over data, zero stuffing applied
// - Host sends bytes only while ready shown
// - Host ends frame by silence, ignores ready
// - Missing byte ends frame, sends check sequence
// - Ready again after first closing flag
// - Receive hunts flags, destuffs, checks, forwards bytes
// - Host rate at least the line rate
// - Eight-bit data; ninth bit escape or marker
// - Closing flag: forward bytes, then evaluate check
// - Result character G, e or A
// - Frame end pin high with result, if selected
// - Ninth bit marks result in configured mode
// - Marker drops when next frame starts
// - Host samples marker with every byte
// - Connection reported by c, d or v
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "hfu_consts.svh"
module hfu_device (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    hfu_link_if.dev         link,
    input  wire logic       frame_mode_enable_i,       // Framing wanted
    input  wire logic       nine_bit_mode_i,           // 9-bit characters
    input  wire logic       ninth_bit_escape_enable_i, // Escape on bit 8
    input  wire logic       ninth_bit_function_i,      // Bit 8 as marker
    input  wire logic       ninth_data_select_i,       // Bit 8 carries data
    input  wire logic       pin1_function_select_i,    // Pin as frame end
    input  wire logic       connect_i,                 // Call is up
    input  wire logic [1:0] connect_kind_i,            // 0 c, 1 d, 2 v
    input  wire logic       line_tx_req_i,             // Pump wants a bit
    output logic            line_tx_bit_o,             // Bit to the line
    input  wire logic       line_rx_valid_i,           // Bit from the line
    input  wire logic       line_rx_bit_i,
    input  wire logic       plain_rx_valid_i,          // Unframed receive
    input  wire logic [7:0] plain_rx_data_i,
    output logic            plain_tx_valid_o,          // Unframed transmit
    output logic [7:0]      plain_tx_data_o,
    output logic            escape_o,                  // Escape request
    output logic            general_pin_one_o          // Frame end pin
);
    import hfu_pkg::*;

    // ======================================================
    // Call state
    logic          conn_prev_reg;   // Connect seen last cycle
    logic          announced_reg;   // Connect character sent
    logic          active;          // Framed data exchange running
    logic          announce;        // Send connect character now
    logic [7:0]    conn_char;

    assign announce = connect_i & ~conn_prev_reg;
    assign active   = frame_mode_enable_i & connect_i & announced_reg;
    assign conn_char = (connect_kind_i == 2'd2) ? `HFU_CHAR_CONN_V :
                       (connect_kind_i == 2'd1) ? `HFU_CHAR_CONN_D :
                                                  `HFU_CHAR_CONN_C;

    // Track connect; framing waits until the report has gone out
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conn_prev_reg <= 1'b0;
            announced_reg <= 1'b0;
        end else begin
            conn_prev_reg <= connect_i;
            announced_reg <= connect_i & (announced_reg | announce);
        end
    end

    // ======================================================
    // Host character intake
    logic          hold_valid_reg;  // One byte waiting for the line
    logic [7:0]    hold_byte_reg;
    logic          tx_eof_reg;      // From frame end until first flag out
    logic          tx_load;         // Sequencer takes the held byte
    logic          h2d_esc;         // Character is an escape request

    assign h2d_esc = nine_bit_mode_i & ninth_bit_escape_enable_i
                   & link.h2d_char[8];
    // Busy while a byte waits or the frame is being closed
    assign link.cts_n = active & (hold_valid_reg | tx_eof_reg);

    // Hold register; the set cannot meet a load since ready was high
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_valid_reg <= 1'b0;
            hold_byte_reg  <= 8'h00;
        end else if (link.h2d_valid & ~h2d_esc & active) begin
            hold_valid_reg <= 1'b1;
            hold_byte_reg  <= link.h2d_char[7:0];  // Bit 8 dropped
        end else if (tx_load | ~active) begin
            hold_valid_reg <= 1'b0;
        end
    end

    // Escape pulse and unframed pass-through to the pump
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            escape_o         <= 1'b0;
            plain_tx_valid_o <= 1'b0;
            plain_tx_data_o  <= 8'h00;
        end else begin
            escape_o         <= link.h2d_valid & h2d_esc;
            plain_tx_valid_o <= link.h2d_valid & ~h2d_esc
                              & ~frame_mode_enable_i;
            if (link.h2d_valid) begin
                plain_tx_data_o <= link.h2d_char[7:0];
            end
        end
    end

    // ======================================================
    // Transmit sequencer
    hfu_tx_state_t tx_state_reg;
    logic [15:0]   tx_sr_reg;       // Bits still to go, low first
    logic [4:0]    tx_cnt_reg;      // Bits left in this unit
    logic [2:0]    tx_ones_reg;     // Run of ones for stuffing
    logic [15:0]   tx_crc_reg;
    logic          tx_step;
    logic          tx_stuffed;      // Sections subject to stuffing
    logic          tx_stuff;
    logic          tx_last;
    logic [15:0]   tx_crc_next;

    assign tx_step     = line_tx_req_i & active & (tx_state_reg != TX_IDLE);
    assign tx_stuffed  = (tx_state_reg == TX_DATA) | (tx_state_reg == TX_FCS);
    // Not gated by section: a run of five ending the check sequence still
    // needs its zero before the closing flag; flags never count ones
    assign tx_stuff    = (tx_ones_reg == `HFU_STUFF_ONES);
    assign tx_last     = (tx_cnt_reg == 5'd1);
    assign tx_crc_next = hfu_crc_bit(tx_crc_reg, tx_sr_reg[0]);
    assign tx_load     = tx_step & ~tx_stuff & tx_last & hold_valid_reg
                       & (((tx_state_reg == TX_FLAG) & ~tx_eof_reg)
                          | (tx_state_reg == TX_DATA));

    // One line bit per pump request; stuffed zeros do not consume data
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state_reg  <= TX_IDLE;
            tx_sr_reg     <= 16'h0000;
            tx_cnt_reg    <= 5'd0;
            tx_ones_reg   <= 3'd0;
            tx_crc_reg    <= `HFU_CRC_INIT;
            tx_eof_reg    <= 1'b0;
            line_tx_bit_o <= 1'b1;
        end else if (!active) begin
            // Marks on the line outside framed operation
            tx_state_reg  <= TX_IDLE;
            tx_eof_reg    <= 1'b0;
            tx_ones_reg   <= 3'd0;
            line_tx_bit_o <= 1'b1;
        end else if (tx_state_reg == TX_IDLE) begin
            tx_state_reg <= TX_FLAG;
            tx_sr_reg    <= {8'h00, `HFU_FLAG};
            tx_cnt_reg   <= `HFU_BYTE_BITS;
        end else if (tx_step && tx_stuff) begin
            line_tx_bit_o <= 1'b0;
            tx_ones_reg   <= 3'd0;
        end else if (tx_step) begin
            line_tx_bit_o <= tx_sr_reg[0];
            tx_sr_reg     <= tx_sr_reg >> 1;
            tx_cnt_reg    <= tx_cnt_reg - 5'd1;
            tx_ones_reg   <= (tx_stuffed & tx_sr_reg[0])
                           ? tx_ones_reg + 3'd1 : 3'd0;
            if (tx_state_reg == TX_DATA) begin
                tx_crc_reg <= tx_crc_next;
            end
            if (tx_last) begin
                case (tx_state_reg)
                    TX_FLAG: begin
                        tx_eof_reg <= 1'b0;
                        tx_cnt_reg <= `HFU_BYTE_BITS;
                        if (tx_load) begin
                            tx_state_reg <= TX_DATA;
                            tx_sr_reg    <= {8'h00, hold_byte_reg};
                            tx_crc_reg   <= `HFU_CRC_INIT;
                            tx_ones_reg  <= 3'd0;
                        end else begin
                            tx_sr_reg <= {8'h00, `HFU_FLAG};
                        end
                    end
                    TX_DATA: begin
                        if (tx_load) begin
                            tx_sr_reg  <= {8'h00, hold_byte_reg};
                            tx_cnt_reg <= `HFU_BYTE_BITS;
                        end else begin
                            // Nothing arrived: close the frame
                            tx_state_reg <= TX_FCS;
                            tx_sr_reg    <= ~tx_crc_next;
                            tx_cnt_reg   <= `HFU_FCS_BITS;
                            tx_eof_reg   <= 1'b1;
                        end
                    end
                    default: begin
                        tx_state_reg <= TX_FLAG;
                        tx_sr_reg    <= {8'h00, `HFU_FLAG};
                        tx_cnt_reg   <= `HFU_BYTE_BITS;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // Receive hunter
    hfu_rx_state_t rx_state_reg;
    logic [7:0]    rx_byte_reg;     // Destuffed bits, newest on top
    logic [2:0]    rx_cnt_reg;
    logic [2:0]    rx_ones_reg;     // Saturates at seven
    logic [15:0]   rx_crc_reg;
    logic          rx_step;
    logic          rx_flag;
    logic          rx_abort;
    logic          rx_data;
    logic          rx_done;         // A whole byte is complete
    logic          rx_result;       // A frame ends here
    logic [7:0]    rx_byte_next;
    logic [7:0]    rx_res_char;

    assign rx_step  = line_rx_valid_i & active;
    assign rx_flag  = rx_step & ~line_rx_bit_i
                    & (rx_ones_reg == `HFU_FLAG_ONES);
    assign rx_abort = rx_step & line_rx_bit_i
                    & (rx_ones_reg == `HFU_FLAG_ONES);
    // Zero after five ones is stuffing; after an abort run it is idle
    assign rx_data  = rx_step & (rx_state_reg != RX_HUNT) & ~rx_abort
                    & (line_rx_bit_i | (rx_ones_reg < `HFU_STUFF_ONES));
    assign rx_byte_next = {line_rx_bit_i, rx_byte_reg[7:1]};
    assign rx_done   = rx_data & (rx_cnt_reg == 3'd7);
    assign rx_result = (rx_flag | rx_abort) & (rx_state_reg == RX_FRAME);
    assign rx_res_char = rx_abort ? `HFU_CHAR_ABORT :
                         (rx_crc_reg == `HFU_CRC_GOOD) ? `HFU_CHAR_GOOD
                                                       : `HFU_CHAR_ERR;

    // Flags open and close frames; bytes run the check as they complete
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_state_reg <= RX_HUNT;
            rx_byte_reg  <= 8'h00;
            rx_cnt_reg   <= 3'd0;
            rx_ones_reg  <= 3'd0;
            rx_crc_reg   <= `HFU_CRC_INIT;
        end else if (!active) begin
            rx_state_reg <= RX_HUNT;
            rx_ones_reg  <= 3'd0;
        end else if (rx_step) begin
            rx_ones_reg <= !line_rx_bit_i ? 3'd0 :
                           (rx_ones_reg == `HFU_ABORT_ONES) ? rx_ones_reg
                                                 : rx_ones_reg + 3'd1;
            if (rx_flag) begin
                rx_state_reg <= RX_OPEN;
                rx_cnt_reg   <= 3'd0;
            end else if (rx_abort) begin
                rx_state_reg <= RX_HUNT;
            end else if (rx_data) begin
                rx_byte_reg <= rx_byte_next;
                rx_cnt_reg  <= rx_cnt_reg + 3'd1;
                if (rx_done) begin
                    rx_state_reg <= RX_FRAME;
                    rx_crc_reg   <= hfu_crc_byte(
                        (rx_state_reg == RX_OPEN) ? `HFU_CRC_INIT
                                                  : rx_crc_reg,
                        rx_byte_next);
                end
            end
        end
    end

    // ======================================================
    // Characters to the host and the frame end marker
    logic          frame_end_reg;   // Result shown, next frame not begun
    logic          mark_ninth;      // Ninth bit used as the marker

    assign mark_ninth = nine_bit_mode_i & ninth_bit_escape_enable_i
                      & ninth_bit_function_i & ninth_data_select_i;
    assign link.frame_end_marker = frame_end_reg;
    assign general_pin_one_o = pin1_function_select_i & frame_end_reg;

    // Marker rises with the result and falls on the next frame's byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_end_reg <= 1'b0;
        end else if (rx_result) begin
            frame_end_reg <= 1'b1;
        end else if (rx_done & (rx_state_reg == RX_OPEN)) begin
            frame_end_reg <= 1'b0;
        end
    end

    // One character per cycle at most: events come one line bit apart
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link.d2h_valid <= 1'b0;
            link.d2h_char  <= 9'h000;
        end else if (announce) begin
            link.d2h_valid <= 1'b1;
            link.d2h_char  <= {1'b0, conn_char};
        end else if (rx_result) begin
            link.d2h_valid <= 1'b1;
            link.d2h_char  <= {mark_ninth, rx_res_char};
        end else if (rx_done) begin
            link.d2h_valid <= 1'b1;
            link.d2h_char  <= {1'b0, rx_byte_next};
        end else if (plain_rx_valid_i & ~frame_mode_enable_i) begin
            link.d2h_valid <= 1'b1;
            link.d2h_char  <= {1'b0, plain_rx_data_i};
        end else begin
            link.d2h_valid <= 1'b0;
        end
    end
endmodule

// ---- rtl/hfu_host.sv ----
// Host controller end: software queues bytes and reads characters.
// Assumes a plain register port; correction is left to software.
`timescale 1ns/1ps
`include "hfu_consts.svh"
module hfu_host (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    hfu_link_if.host        link,
    input  wire logic [3:0] addr_i,       // Byte address
    input  wire logic [31:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [31:0]     rdata_o       // Valid the cycle after rd_i
);
    import hfu_pkg::*;

    // ======================================================
    // Transmit side
    logic          tx_pend_reg;     // Character waits for ready
    hfu_char_t     tx_char_reg;
    logic          tx_send;

    // Frames end only by not writing; ready while idle is ignored
    assign tx_send        = tx_pend_reg & ~link.cts_n;
    assign link.h2d_valid = tx_send;
    assign link.h2d_char  = tx_char_reg;

    // Software write queues one character; a send clears it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_pend_reg <= 1'b0;
            tx_char_reg <= 9'h000;
        end else if (wr_i && addr_i == `HFU_ADDR_TX) begin
            tx_pend_reg <= 1'b1;
            tx_char_reg <= wdata_i[8:0];
        end else if (tx_send) begin
            tx_pend_reg <= 1'b0;
        end
    end

    // ======================================================
    // Receive side
    logic          rx_avail_reg;    // Unread character held
    logic          rx_over_reg;     // Character lost before a read
    hfu_char_t     rx_char_reg;
    logic          rx_mark_reg;     // Marker pin sampled with byte
    logic          rx_read;

    assign rx_read = rd_i && addr_i == `HFU_ADDR_RX;

    // Capture each character with its marker; arrival beats a clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_avail_reg <= 1'b0;
            rx_over_reg  <= 1'b0;
            rx_char_reg  <= 9'h000;
            rx_mark_reg  <= 1'b0;
        end else if (link.d2h_valid) begin
            rx_avail_reg <= 1'b1;
            rx_over_reg  <= rx_over_reg | (rx_avail_reg & ~rx_read);
            rx_char_reg  <= link.d2h_char;
            rx_mark_reg  <= link.frame_end_marker;
        end else if (rx_read) begin
            rx_avail_reg <= 1'b0;
            rx_over_reg  <= 1'b0;
        end
    end

    // ======================================================
    // Register reads; unmapped addresses return zero
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i && addr_i == `HFU_ADDR_RX) begin
            rdata_o <= {22'h0, rx_mark_reg, rx_char_reg};
        end else if (rd_i && addr_i == `HFU_ADDR_STAT) begin
            rdata_o <= {28'h0, rx_over_reg, rx_avail_reg,
                        ~link.cts_n, tx_pend_reg};
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// ---- tb/hfu_link_assertions.sv ----
// Checker for the character link between host and framing device.
// Assumes it sits beside the interface; all signals on one clock.
`timescale 1ns/1ps
module hfu_link_checker (
    input logic               clk_i,
    input logic               nrst_i,
    input logic               h2d_valid,
    input hfu_pkg::hfu_char_t h2d_char,
    input logic               cts_n,
    input logic               d2h_valid,
    input hfu_pkg::hfu_char_t d2h_char,
    input logic               frame_end_marker
);
    import hfu_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ==========================================================
    // Steps of a transfer
    sequence byte_taken; h2d_valid && !h2d_char[8]; endsequence
    sequence result_out; d2h_valid && d2h_char[8]; endsequence
    // ==========================================================
    // Link properties
    send_gate_a: assert property (h2d_valid |-> !cts_n)
        else $error("host char sent while not ready");
    hold_after_a: assert property (byte_taken |=> cts_n)
        else $error("ready kept after a taken byte");
    pulse_one_a: assert property (d2h_valid |=> !d2h_valid)
        else $error("char strobe longer than one cycle");
    char_hold_a: assert property ($changed(d2h_char) |-> d2h_valid)
        else $error("char changed without strobe");
    result_mark_a: assert property (result_out |-> frame_end_marker)
        else $error("result char without marker");
    result_code_a: assert property (result_out |->
        d2h_char[7:0] inside {8'h47, 8'h65, 8'h41})
        else $error("bad result code");
    mark_rise_a: assert property ($rose(frame_end_marker) |-> result_out)
        else $error("marker rose without result");
    mark_fall_a: assert property ($fell(frame_end_marker) |->
        d2h_valid || $past(d2h_valid))
        else $error("marker fell without a byte");
endmodule

// ---- tb/tb_hdlc_frame_uart_bridge.sv ----
// Testbench: host and device ends joined by the link, line looped back.
// Assumes the rtl files are compiled first; one 250 MHz clock.
`timescale 1ns/1ps
module tb_hdlc_frame_uart_bridge;
    import hfu_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_i = 0, nrst_i = 0, cfg = 0, fm = 0, con = 0;
    logic        txr = 0, rxv = 0, wr = 0, rd = 0, esc, txb, ph_w;
    logic        prv = 0, ptv;
    logic [7:0]  prd = 0, ptd;
    logic [1:0]  kind = 0, ph = 0;
    logic [3:0]  addr = 0;
    logic [31:0] wd = 0, rdata;
    logic [7:0]  cc [3] = '{8'h63, 8'h64, 8'h76};
    hfu_char_t   exp_q [$];
    int          num_errors = 0, check_count = 0;
    always #2 clk_i = ~clk_i;
    // Pump strobes one bit every four cycles; line is looped back
    always @(posedge clk_i) begin
        ph  <= ph + 2'd1;
        txr <= (ph == 2'd3);
        rxv <= txr;
    end
    hfu_link_if link();
    hfu_device hfu_device_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
        .frame_mode_enable_i(fm), .nine_bit_mode_i(cfg),
        .ninth_bit_escape_enable_i(cfg), .ninth_bit_function_i(cfg),
        .ninth_data_select_i(cfg), .pin1_function_select_i(cfg),
        .connect_i(con), .connect_kind_i(kind), .line_tx_req_i(txr),
        .line_tx_bit_o(txb), .line_rx_valid_i(rxv), .line_rx_bit_i(txb),
        .plain_rx_valid_i(prv), .plain_rx_data_i(prd),
        .plain_tx_valid_o(ptv), .plain_tx_data_o(ptd), .escape_o(esc),
        .general_pin_one_o(ph_w));
    hfu_host hfu_host_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
        .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    hfu_link_checker hfu_link_checker_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .h2d_valid(link.h2d_valid), .h2d_char(link.h2d_char),
        .cts_n(link.cts_n), .d2h_valid(link.d2h_valid),
        .d2h_char(link.d2h_char), .frame_end_marker(link.frame_end_marker));
    // ==========================================================
    // Tasks
    task chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a; wd <= d; wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr <= a; rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        chk(rdata === e, "register read mismatch");
    endtask
    function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        return c;
    endfunction
    // Monitor takes the oldest note whenever the device shows a char
    always @(negedge clk_i) begin
        if (nrst_i && link.d2h_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(0, "unexpected char");
            else begin
                chk(link.d2h_char === exp_q[0], "char mismatch");
                chk(!exp_q[0][8] || ph_w === 1'b1, "pin low");
                void'(exp_q.pop_front());
            end
        end
    end
    // ==========================================================
    // Main sequence
    // A used-up wait returns early so the verdict follows at once
    task run_scen;
        int n;
        logic [7:0] d;
        logic [15:0] crc;
        void'($urandom(88470));
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk(link.cts_n === 1'b0, "not ready unframed");
        // Unframed bytes pass straight; bit 8 ignored without escape
        d = $urandom;
        exp_q.push_back({1'b0, d});
        @(posedge clk_i);
        prd <= d; prv <= 1'b1;
        @(posedge clk_i);
        prv <= 1'b0;
        wr_reg(4'h0, {23'h0, 1'b1, ~d});
        repeat (2) @(negedge clk_i);
        chk(ptv === 1'b1 && ptd === ~d && esc === 1'b0, "plain tx");
        cfg <= 1'b1; fm <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            con <= 1'b0; kind <= k[1:0];
            repeat (8) @(posedge clk_i);
            exp_q.push_back({1'b0, cc[k]});
            con <= 1'b1;
            repeat (60) @(posedge clk_i);
        end
        // Frames of two and three random bytes, checked after loopback
        for (int f = 0; f < 2; f++) begin
            crc = 16'hffff;
            for (int i = 0; i < f + 2; i++) begin
                d = $urandom;
                crc = crc_upd(crc, d);
                exp_q.push_back({1'b0, d});
                wr_reg(4'h0, {24'h0, d});
                for (n = 0; n < 400 && link.h2d_valid !== 1'b1; n++) @(negedge clk_i);
                chk(n < 400, "byte not handed over");
                if (n >= 400) return;
            end
            crc = ~crc;
            exp_q.push_back({1'b0, crc[7:0]});
            exp_q.push_back({1'b0, crc[15:8]});
            exp_q.push_back({1'b1, 8'h47});
            for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(negedge clk_i);
            chk(n < 3000, "frame not received");
            if (n >= 3000) return;
        end
        rd_reg(4'h4, {22'h0, 1'b1, 9'h147});
        rd_reg(4'h8, 32'h2);
        rd_reg(4'hc, 32'h0);
        wr_reg(4'h0, 32'h100);
        for (n = 0; n < 50 && esc !== 1'b1; n++) @(negedge clk_i);
        chk(n < 50, "no escape pulse");
        if (n >= 50) return;
        repeat (300) @(posedge clk_i);
    endtask
    initial begin
        run_scen();
        give_verdict();
    end
endmodule
